// ==== design/swtl_pkg.sv ====
package swtl_pkg;

	// ************************************************************
	// Serial frame layout
	// ************************************************************
	localparam int          FRAME_BITS  = 32;     // Bits in one serial word
	localparam int          CNT_W       = 6;      // Bit counter width
	localparam logic [5:0]  FRAME_LAST  = 6'h20;  // Count at a complete word
	localparam int          ADDR_W      = 7;      // Register address width
	localparam int          DATA_W      = 24;     // Data field width

	// ************************************************************
	// Register addresses
	// ************************************************************
	localparam logic [6:0]  ADDR_FLOAT      = 7'h03; // ground_input_float_ctrl
	localparam logic [6:0]  ADDR_PLVL_LO    = 7'h04; // prog_input_level_low
	localparam logic [6:0]  ADDR_GLVL_LO    = 7'h05; // ground_input_level_low
	localparam logic [6:0]  ADDR_PLVL_HI    = 7'h08; // prog_input_level_high
	localparam logic [6:0]  ADDR_FAULT_STAT = 7'h0c; // Fault status, held elsewhere

	// ************************************************************
	// Field positions and widths
	// ************************************************************
	localparam int          FAULT_BIT   = 23;     // Fault flag position
	localparam int          INT_BIT     = 22;     // Interrupt flag position
	localparam int          GND_N       = 21;     // Ground inputs
	localparam int          LVL_W       = 3;      // Level code width
	localparam int          LVL_LO_N    = 8;      // Fields in a full level word
	localparam int          PLVL_HI_N   = 4;      // Fields in the high prog word
	localparam int          CUR_W       = 8;      // Current in 0.1 mA units

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [20:0] FLOAT_RST   = 21'h1fffff; // All inputs floated
	localparam logic [2:0]  LVL_RST     = 3'h6;       // 16 mA code

	// ************************************************************
	// Carriers
	// ************************************************************
	typedef struct packed {
		logic [6:0]  addr;   // Register address
		logic        wr;     // 1 = write
		logic [23:0] data;   // Data field
	} swtl_frame_t;

	typedef struct packed {
		logic fault;         // Fault flag
		logic intr;          // Interrupt flag
	} swtl_flags_t;

	// Level code to current in tenths of a milliamp
	function automatic logic [7:0] swtl_lvl_to_cur(input logic [2:0] code);
		case (code)
			3'h0:    swtl_lvl_to_cur = 8'h14;  // 2.0 mA
			3'h1:    swtl_lvl_to_cur = 8'h3c;  // 6.0 mA
			3'h2:    swtl_lvl_to_cur = 8'h50;  // 8.0 mA
			3'h3:    swtl_lvl_to_cur = 8'h64;  // 10 mA
			3'h4:    swtl_lvl_to_cur = 8'h78;  // 12 mA
			3'h5:    swtl_lvl_to_cur = 8'h8c;  // 14 mA
			3'h6:    swtl_lvl_to_cur = 8'ha0;  // 16 mA
			default: swtl_lvl_to_cur = 8'hc8;  // 20 mA
		endcase
	endfunction

endpackage

// ==== design/swtl_regs.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Floated ground input: source off regardless
// - Comparators stay enabled while floated
// - Float register writable anytime in normal mode
// - Float bits reset to one
// - Sleep polls sample floated inputs, sources off
// - Change detect and wake at poll end
// - Float register: bit n per input, flags
// - Each input uses its own level field; code has ground fields for inputs 0-7 only
// - Level fields reset to 16 mA code
// - Level registers writable anytime in normal mode
// - Prog low level: eight fields, no flags
// - Prog high level: four fields, flags
// - Ground low level: eight fields, no flags
// - Level codes decode to eight currents
// - Interrupt flag cleared by flagged access
// - Fault flag cleared on clean status read
module swtl_regs
	import swtl_pkg::*;
(
	input  wire logic                    CLOCK_IN,           // 100 MHz
	input  wire logic                    RST_N_IN,           // Async, active low
	input  wire logic                    SCLK_IN,            // Serial clock pin
	input  wire logic                    CS_N_IN,            // Chip select pin
	input  wire logic                    MOSI_IN,            // Serial data in pin
	output logic                         MISO_OUT,           // Serial data out
	output logic                         MISO_OE_N_OUT,      // Low while driving
	input  wire logic                    SLEEP_POLL_MODE_IN, // Low-power mode
	input  wire logic                    POLL_ACTIVE_IN,     // Active poll interval
	input  wire logic [GND_N-1:0]        GND_SWITCH_IN,      // Comparator results
	input  wire logic                    INT_EVENT_IN,       // Interrupt event pulse
	input  wire logic                    FAULT_EVENT_IN,     // Fault event pulse
	input  wire logic                    FAULT_ACTIVE_IN,    // Fault still present
	output logic [GND_N-1:0]             GND_FLOAT_OUT,      // Input floated
	output logic [GND_N-1:0]             GND_SOURCE_EN_OUT,  // Current source on
	output logic [GND_N-1:0]             GND_CMP_EN_OUT,     // Comparator on
	output logic [LVL_LO_N*CUR_W-1:0]    GND_CUR_OUT,        // Ground 0-7 currents
	output logic [3*LVL_LO_N*LVL_W/2-1:0] PROG_LVL_OUT,      // Prog 0-11 codes
	output logic [LVL_LO_N*LVL_W-1:0]    GND_LVL_OUT,        // Ground 0-7 codes
	output swtl_flags_t                  FLAGS_OUT,          // Fault and interrupt
	output logic                         WAKE_OUT            // Wake pulse
);

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0]        sclk_sync;   // Stage 0 feeds stage 1 only
	logic [2:0]        cs_sync;     // Same, stage 2 is edge history
	logic [1:0]        mosi_sync;   // Data line
	logic [GND_N-1:0]  sw_meta;     // Comparator first stage
	logic [GND_N-1:0]  sw_sync;     // Comparator second stage

	// Two flops before any logic, third for edges
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			sclk_sync <= 3'h0;
			cs_sync   <= 3'h7;
			mosi_sync <= 2'h0;
			sw_meta   <= '0;
			sw_sync   <= '0;
		end else begin
			sclk_sync <= {sclk_sync[1:0], SCLK_IN};
			cs_sync   <= {cs_sync[1:0], CS_N_IN};
			mosi_sync <= {mosi_sync[0], MOSI_IN};
			sw_meta   <= GND_SWITCH_IN;
			sw_sync   <= sw_meta;
		end
	end

	logic sclk_rise;  // Sample edge
	logic sclk_fall;  // Shift-out edge
	logic cs_start;   // Select asserted
	logic cs_end;     // Select released
	assign sclk_rise = sclk_sync[1] & ~sclk_sync[2] & ~cs_sync[1];
	assign sclk_fall = ~sclk_sync[1] & sclk_sync[2] & ~cs_sync[1];
	assign cs_start  = ~cs_sync[1] & cs_sync[2];
	assign cs_end    = cs_sync[1] & ~cs_sync[2];

	// ************************************************************
	// Serial shifter
	// ************************************************************
	logic [FRAME_BITS-1:0] shift_in;   // Incoming word
	logic [FRAME_BITS-1:0] shift_out;  // Outgoing word
	logic [CNT_W-1:0]      bit_cnt;    // Bits taken this frame
	swtl_frame_t           resp;       // Answer for the next frame
	swtl_frame_t           frame;      // Decoded incoming word
	logic                  commit;     // Complete word accepted

	assign frame  = swtl_frame_t'(shift_in);
	// Short or long frames are dropped whole, nothing half-applied
	assign commit = cs_end & (bit_cnt == FRAME_LAST);

	// Shift in on rising edge, out on falling edge
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			shift_in  <= '0;
			shift_out <= '0;
			bit_cnt   <= '0;
		end else if (cs_start) begin
			// Previous frame's answer goes out now
			shift_out <= resp;
			bit_cnt   <= '0;
		end else begin
			if (sclk_rise) begin
				shift_in <= {shift_in[FRAME_BITS-2:0], mosi_sync[1]};
				if (bit_cnt != '1)
					bit_cnt <= bit_cnt + CNT_W'(1);
			end
			if (sclk_fall)
				shift_out <= {shift_out[FRAME_BITS-2:0], 1'b0};
		end
	end

	// Output pin from flops; released while deselected
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			MISO_OUT      <= 1'b0;
			MISO_OE_N_OUT <= 1'b1;
		end else begin
			MISO_OUT      <= shift_out[FRAME_BITS-1];
			MISO_OE_N_OUT <= cs_sync[1];
		end
	end

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [GND_N-1:0]               float_ctrl; // ground_input_float_ctrl
	logic [DATA_W-1:0]              plvl_lo;    // prog_input_level_low
	logic [DATA_W-1:0]              glvl_lo;    // ground_input_level_low
	logic [PLVL_HI_N*LVL_W-1:0]     plvl_hi;    // prog_input_level_high
	logic                           wr_ok;      // Write allowed now
	swtl_flags_t                    flags;      // Global status flags

	// Writes need only normal mode, nothing else
	assign wr_ok = commit & frame.wr & ~SLEEP_POLL_MODE_IN;

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			float_ctrl <= FLOAT_RST;
		else if (wr_ok && frame.addr == ADDR_FLOAT)
			float_ctrl <= frame.data[GND_N-1:0];
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			plvl_lo <= {LVL_LO_N{LVL_RST}};
			glvl_lo <= {LVL_LO_N{LVL_RST}};
			plvl_hi <= {PLVL_HI_N{LVL_RST}};
		end else if (wr_ok) begin
			if (frame.addr == ADDR_PLVL_LO)
				plvl_lo <= frame.data;
			if (frame.addr == ADDR_GLVL_LO)
				glvl_lo <= frame.data;
			if (frame.addr == ADDR_PLVL_HI)
				plvl_hi <= frame.data[PLVL_HI_N*LVL_W-1:0];
		end
	end

	// ************************************************************
	// Status flags
	// ************************************************************
	logic hit_flagged;  // Access of a word carrying the flags
	logic fault_clr;    // Clean fault status read
	assign hit_flagged = commit & (frame.addr == ADDR_FLOAT || frame.addr == ADDR_PLVL_HI);
	assign fault_clr   = commit & ~frame.wr & (frame.addr == ADDR_FAULT_STAT)
	                     & ~FAULT_ACTIVE_IN;

	// Set beats clear so an event in the clearing cycle survives
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			flags <= '0;
		else begin
			// set by event, cleared by access
			if (INT_EVENT_IN)
				flags.intr <= 1'b1;
			else if (hit_flagged)
				flags.intr <= 1'b0;
			if (FAULT_EVENT_IN)
				flags.fault <= 1'b1;
			else if (fault_clr)
				flags.fault <= 1'b0;
		end
	end

	// ************************************************************
	// Read answer
	// ************************************************************
	logic [DATA_W-1:0] rd_data;  // Data field of the answer

	always_comb begin
		// unmapped and unused bits read zero
		rd_data = '0;
		case (frame.addr)
			ADDR_FLOAT: begin
				rd_data[GND_N-1:0] = float_ctrl;
				rd_data[FAULT_BIT] = flags.fault;
				rd_data[INT_BIT]   = flags.intr;
			end
			ADDR_PLVL_LO: rd_data = plvl_lo;
			ADDR_GLVL_LO: rd_data = glvl_lo;
			ADDR_PLVL_HI: begin
				rd_data[PLVL_HI_N*LVL_W-1:0] = plvl_hi;
				rd_data[FAULT_BIT]           = flags.fault;
				rd_data[INT_BIT]             = flags.intr;
			end
			default: rd_data = '0;
		endcase
	end

	// Answer captured with pre-clear flags, sent next frame
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN)
			resp <= '0;
		else if (commit) begin
			resp.addr <= frame.addr;
			resp.wr   <= frame.wr;
			resp.data <= rd_data;
		end
	end

	// ************************************************************
	// Input drive
	// ************************************************************
	logic src_allowed;  // Sources may run now
	assign src_allowed = ~SLEEP_POLL_MODE_IN | POLL_ACTIVE_IN;

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			GND_SOURCE_EN_OUT <= '0;
			GND_FLOAT_OUT     <= FLOAT_RST;
			GND_CMP_EN_OUT    <= '0;
		end else begin
			GND_SOURCE_EN_OUT <= ~float_ctrl & {GND_N{src_allowed}};
			GND_FLOAT_OUT     <= float_ctrl;
			GND_CMP_EN_OUT    <= '1;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < LVL_LO_N; gi++) begin : g_cur
			always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
				if (!RST_N_IN)
					GND_CUR_OUT[gi*CUR_W +: CUR_W] <= '0;
				else if (float_ctrl[gi])
					GND_CUR_OUT[gi*CUR_W +: CUR_W] <= '0;
				else
					GND_CUR_OUT[gi*CUR_W +: CUR_W] <=
						swtl_lvl_to_cur(glvl_lo[gi*LVL_W +: LVL_W]);
			end
		end
	endgenerate

	// Level codes for the analog sources
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PROG_LVL_OUT <= {(LVL_LO_N+PLVL_HI_N){LVL_RST}};
			GND_LVL_OUT  <= {LVL_LO_N{LVL_RST}};
			FLAGS_OUT    <= '0;
		end else begin
			PROG_LVL_OUT <= {plvl_hi, plvl_lo};
			GND_LVL_OUT  <= glvl_lo;
			FLAGS_OUT    <= flags;
		end
	end

	// ************************************************************
	// Poll end and wake decision
	// ************************************************************
	logic             poll_dly;  // Poll level one cycle ago
	logic             poll_end;  // Interval just ended
	logic [GND_N-1:0] last_sw;   // States at previous poll end
	assign poll_end = poll_dly & ~POLL_ACTIVE_IN;

	// compare at interval end, then wake
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			poll_dly <= 1'b0;
			last_sw  <= '0;
			WAKE_OUT <= 1'b0;
		end else begin
			poll_dly <= POLL_ACTIVE_IN;
			WAKE_OUT <= poll_end & SLEEP_POLL_MODE_IN & (sw_sync != last_sw);
			// Floated inputs are sampled too
			if (poll_end)
				last_sw <= sw_sync;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	AST_FLOAT_NO_SOURCE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		##1 (($past(float_ctrl) & GND_SOURCE_EN_OUT) == '0))
		else $error("Floated input has source on");
	AST_CMP_ALIVE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		$past(RST_N_IN) |-> GND_CMP_EN_OUT == '1)
		else $error("Comparator disabled");
	AST_FLOAT_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ok && frame.addr == ADDR_FLOAT |=> float_ctrl == $past(frame.data[GND_N-1:0]))
		else $error("Float write not applied");
	AST_FLOAT_RESET: assert property (@(posedge CLOCK_IN)
		$rose(RST_N_IN) |-> float_ctrl == FLOAT_RST)
		else $error("Float bits not set after reset");
	AST_SLEEP_QUIET: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		SLEEP_POLL_MODE_IN && !POLL_ACTIVE_IN |=> GND_SOURCE_EN_OUT == '0)
		else $error("Source on between sleep polls");
	AST_WAKE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		poll_end && SLEEP_POLL_MODE_IN && sw_sync != last_sw |=> WAKE_OUT ##1 !WAKE_OUT)
		else $error("Missing wake pulse");
	AST_LEVEL_WRITE: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		wr_ok && frame.addr == ADDR_PLVL_HI |=> ##1
		PROG_LVL_OUT[3*LVL_LO_N*LVL_W/2-1:DATA_W] == $past(frame.data[PLVL_HI_N*LVL_W-1:0], 2))
		else $error("High level write not applied");
	AST_INT_CLEAR: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		hit_flagged && !INT_EVENT_IN |=> !flags.intr)
		else $error("Interrupt flag not cleared");
	AST_INT_SET: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		INT_EVENT_IN |=> flags.intr ##1 FLAGS_OUT.intr)
		else $error("Interrupt flag not set");
	AST_FAULT_HOLD: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		flags.fault && !fault_clr |=> flags.fault)
		else $error("Fault flag dropped early");
	AST_UNUSED_ZERO: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
		commit && frame.addr == ADDR_PLVL_HI |=> resp.data[INT_BIT-1:PLVL_HI_N*LVL_W] == '0)
		else $error("Unused bits not zero");
endmodule

// ==== tb/swtl_host_model.sv ====
`timescale 1ns/10ps
module swtl_host_model
	import swtl_pkg::*;
(
	input  wire logic clk_in,       // Bench system clock
	input  wire logic miso_in,      // Device serial data out
	input  wire logic miso_oe_n_in, // Device drive enable, low active
	output logic      sclk_out,     // Serial clock, idle low
	output logic      cs_n_out,     // Chip select, low active
	output logic      mosi_out      // Serial data to device
);
	// ************************************************************
	// Link timing
	// ************************************************************
	localparam int HALF = 8; // 80 ns half period, well above the 4 cycle minimum

	// Idle link, clock parked low outside frames
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// ************************************************************
	// One full-duplex word
	// ************************************************************
	// 32 bits, MSB first
	task automatic xfer(input swtl_frame_t word, output swtl_frame_t answer);
		logic [FRAME_BITS-1:0] bits;
		bits = word;
		answer = '0;
		@(negedge clk_in);
		cs_n_out = 1'b0;
		repeat (HALF) @(negedge clk_in);
		for (int i = FRAME_BITS - 1; i >= 0; i--) begin
			mosi_out = bits[i];
			repeat (HALF) @(negedge clk_in);
			sclk_out = 1'b1;
			// Undriven line must never pass for data
			answer[i] = (miso_oe_n_in === 1'b0) ? miso_in : 1'bx;
			repeat (HALF) @(negedge clk_in);
			sclk_out = 1'b0;
		end
		repeat (HALF) @(negedge clk_in);
		cs_n_out = 1'b1;
		// Released line does not keep the last bit
		mosi_out = ~mosi_out;
		repeat (2 * HALF) @(negedge clk_in);
	endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
	import swtl_pkg::*;
;
	// ************************************************************
	// Bench signals
	// ************************************************************
	logic        clock = 1'b0;      // 100 MHz
	logic        rst_n = 1'b0;      // Async reset, low active
	logic        sclk, cs_n, mosi;  // Link from host model
	logic        miso, miso_oe_n;   // Link back to host model
	logic        sleep = 1'b0;      // Low-power mode
	logic        poll = 1'b0;       // Active poll interval
	logic [20:0] sw = '0;           // Comparator results
	logic        int_ev = 1'b0;     // Interrupt event pulse
	logic        fault_ev = 1'b0;   // Fault event pulse
	logic        fault_act = 1'b0;  // Fault still present
	logic [20:0] float_o, src_o, cmp_o;
	logic [63:0] cur_o;
	logic [35:0] plvl_o;
	logic [23:0] glvl_o;
	swtl_flags_t flags_o;
	logic        wake_o;
	int          failures = 0;
	int          checks_done = 0;
	int          wake_cnt = 0;
	// Expected currents per code, tenths of a milliamp
	logic [7:0]  cur_tab [8] = '{8'h14, 8'h3c, 8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0, 8'hc8};

	always #5 clock = ~clock;

	// Wake pulses counted so no single edge is missed
	always @(posedge clock) begin
		if (wake_o === 1'b1) begin
			wake_cnt++;
		end
	end

	swtl_regs i_swtl_regs (.CLOCK_IN(clock), .RST_N_IN(rst_n), .SCLK_IN(sclk), .CS_N_IN(cs_n),
		.MOSI_IN(mosi), .MISO_OUT(miso), .MISO_OE_N_OUT(miso_oe_n),
		.SLEEP_POLL_MODE_IN(sleep), .POLL_ACTIVE_IN(poll), .GND_SWITCH_IN(sw),
		.INT_EVENT_IN(int_ev), .FAULT_EVENT_IN(fault_ev), .FAULT_ACTIVE_IN(fault_act),
		.GND_FLOAT_OUT(float_o), .GND_SOURCE_EN_OUT(src_o), .GND_CMP_EN_OUT(cmp_o),
		.GND_CUR_OUT(cur_o), .PROG_LVL_OUT(plvl_o), .GND_LVL_OUT(glvl_o),
		.FLAGS_OUT(flags_o), .WAKE_OUT(wake_o));

	swtl_host_model i_swtl_host_model (.clk_in(clock), .miso_in(miso),
		.miso_oe_n_in(miso_oe_n), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [23:0] d);
		swtl_frame_t ans;
		i_swtl_host_model.xfer({a, 1'b1, d}, ans);
	endtask

	// Answer arrives one frame late, so a read costs two words
	task automatic rd(input logic [6:0] a, output logic [23:0] d);
		swtl_frame_t ans;
		i_swtl_host_model.xfer({a, 1'b0, 24'h0}, ans);
		i_swtl_host_model.xfer({a, 1'b0, 24'h0}, ans);
		chk("answer addr", 64'(a), 64'(ans.addr));
		d = ans.data;
	endtask

	// One-cycle event pulse, fault or interrupt
	task automatic pulse(input logic on_fault);
		@(negedge clock);
		if (on_fault) begin
			fault_ev = 1'b1;
		end else begin
			int_ev = 1'b1;
		end
		@(negedge clock);
		fault_ev = 1'b0;
		int_ev = 1'b0;
		repeat (4) @(negedge clock);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		logic [23:0] d;
		chk("float rst", 64'h1fffff, 64'(float_o));
		chk("glvl rst", 64'hdb6db6, 64'(glvl_o));
		chk("plvl rst", 64'hdb6db6db6, 64'(plvl_o));
		chk("src rst", 64'h0, 64'(src_o));
		chk("cmp rst", 64'h1fffff, 64'(cmp_o));
		rd(ADDR_FLOAT, d);
		chk("float rd", 64'h1fffff, 64'(d));
	endtask

	// Reset in mid-run brings back the power-on values
	task automatic t_rerst();
		wr(ADDR_GLVL_LO, 24'h0);
		chk("glvl zero", 64'h0, 64'(glvl_o));
		@(negedge clock);
		rst_n = 1'b0;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		chk("float rerst", 64'h1fffff, 64'(float_o));
		chk("glvl rerst", 64'hdb6db6, 64'(glvl_o));
		chk("plvl rerst", 64'hdb6db6db6, 64'(plvl_o));
	endtask

	task automatic t_float();
		logic [23:0] d;
		wr(ADDR_FLOAT, 24'hf5a5a5);
		chk("float wr", 64'h15a5a5, 64'(float_o));
		chk("src wr", 64'h0a5a5a, 64'(src_o));
		rd(ADDR_FLOAT, d);
		chk("float rb", 64'h15a5a5, 64'(d));
	endtask

	task automatic t_levels();
		logic [23:0] d;
		wr(ADDR_FLOAT, 24'h0);
		wr(ADDR_GLVL_LO, 24'hfac688);
		chk("glvl", 64'hfac688, 64'(glvl_o));
		for (int i = 0; i < 8; i++) begin
			chk("cur code", 64'(cur_tab[i]), 64'(cur_o[i*8 +: 8]));
		end
		rd(ADDR_GLVL_LO, d);
		chk("glvl rd", 64'hfac688, 64'(d));
		wr(ADDR_FLOAT, 24'h000001);
		chk("cur floated", 64'hc8a08c7864503c00, cur_o);
		chk("cur kept", 64'(cur_tab[1]), 64'(cur_o[15:8]));
	endtask

	task automatic t_prog();
		logic [23:0] d;
		wr(ADDR_PLVL_LO, 24'h123456);
		wr(ADDR_PLVL_HI, 24'hffffff);
		chk("plvl", 64'hfff123456, 64'(plvl_o));
		rd(ADDR_PLVL_HI, d);
		chk("plvl hi rd", 64'h000fff, 64'(d));
		rd(ADDR_PLVL_LO, d);
		chk("plvl lo rd", 64'h123456, 64'(d));
	endtask

	task automatic t_flags();
		logic [23:0] d;
		pulse(1'b0);
		chk("intr set", 64'h1, 64'(flags_o.intr));
		rd(ADDR_PLVL_LO, d);
		chk("intr kept", 64'h1, 64'(flags_o.intr));
		rd(ADDR_PLVL_HI, d);
		chk("intr in word", 64'h1, 64'(d[INT_BIT]));
		chk("intr clr", 64'h0, 64'(flags_o.intr));
		fault_act = 1'b1;
		pulse(1'b1);
		rd(ADDR_FAULT_STAT, d);
		chk("fault held", 64'h1, 64'(flags_o.fault));
		rd(ADDR_FLOAT, d);
		chk("fault in word", 64'h1, 64'(d[FAULT_BIT]));
		fault_act = 1'b0;
		rd(ADDR_FAULT_STAT, d);
		chk("fault clr", 64'h0, 64'(flags_o.fault));
		rd(7'h7f, d);
		chk("unmapped", 64'h0, 64'(d));
	endtask

	task automatic t_sleep();
		sleep = 1'b1;
		repeat (4) @(negedge clock);
		chk("src idle", 64'h0, 64'(src_o));
		poll = 1'b1;
		repeat (4) @(negedge clock);
		chk("src poll", 64'h1ffffe, 64'(src_o));
		chk("cmp floated", 64'h1fffff, 64'(cmp_o));
		wr(ADDR_FLOAT, 24'h0);
		chk("sleep wr", 64'h000001, 64'(float_o));
		poll = 1'b0;
		repeat (6) @(negedge clock);
		chk("no wake", 64'h0, 64'(wake_cnt));
		sw = 21'h000001;
		repeat (6) @(negedge clock);
		poll = 1'b1;
		repeat (6) @(negedge clock);
		poll = 1'b0;
		repeat (6) @(negedge clock);
		chk("wake", 64'h1, 64'(wake_cnt));
		sleep = 1'b0;
	endtask

	task automatic summarize();
		if (failures == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Watchdog, about four times the expected run
	initial begin
		#640000;
		failures++;
		summarize();
	end

	initial begin
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		repeat (8) @(negedge clock);
		t_reset();
		t_float();
		t_levels();
		t_prog();
		t_flags();
		t_sleep();
		t_rerst();
		summarize();
	end
endmodule
